// >>> core/scb_servo_config_block_handler.v
// Behaviour
// [R1] word 0: mode bit15, command 11:8, block 3:0
// [R2] status reply header 8100, word1 zero
// [R3] word2 firmware major high, minor low
// [R4] words 6,7 copy status words 0,1
// [R5] word8 bus voltage in tenth volts
// [R6] word9 processor temperature in degrees
// [R7] readback decodes only the first word
// [R8] decode 8201..8206 readback selections; 8204 is refused as an unknown block
// [R9] readback reply uses write block layout
// [R10] 820F reloads defaults into working memory
// [R11] data block bit0 selects word order
// [R12] io block header 8A02, inputs words 2-5
// [R13] bit8 sets input polarity
// [R14] bits3-0 function, unique except general
// [R15] host sets inputs 3,4 polarity one
// [R16] host sets inputs 3,4 general purpose
// [R17] general purpose input still reported
// [R18] codes 1,2 are end-of-travel limits
// [R19] code 3 edge captures and starts index
// [R20] code 4 stops move and captures
// [R21] code 5 edge is emergency stop
// [R22] code 6 home; code 7 reserved
// [R23] word6 discrepancy timeout 50-3000 ms, 0 off
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
`include "scb_regs.vh"
module scb_servo_config_block_handler
#(
  parameter FW_MAJOR = 8'h01,    // arbitrary revision value
  parameter FW_MINOR = 8'h00,    // arbitrary revision value
  parameter MS_CYCLES = `SCB_MS_CYCLES
)
(
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire [15:0] statusWord0,
  input  wire [15:0] statusWord1,
  input  wire [15:0] busVoltage,
  input  wire [15:0] cpuTemp,
  input  wire [3:0]  inputPins,
  input  wire        torqueCutoffOption,
  input  wire        thirdInputCutoff,
  input  wire        fourthInputCutoff,
  output reg  [3:0]  inputState,
  output reg         cwLimit,
  output reg         ccwLimit,
  output reg         captureStrobe,
  output reg         indexStart,
  output reg         stopStrobe,
  output reg         emergencyStop,
  output reg         homeSensor,
  output reg         bigEndian,
  output reg         discrepancyFault,
  output reg         configError
);

  // ****************************************************************
  // configuration and reply storage
  // ****************************************************************
  reg  [15:0] cmdWord;
  reg  [15:0] blkWord [0:9];     // write block being assembled by host
  reg  [15:0] respWord [0:9];
  reg  [3:0]  inPolarity;
  reg  [3:0]  inFunc [0:3];
  reg  [15:0] discLimitMs;
  reg  [3:0]  pinSync1;
  reg  [3:0]  pinSync2;
  reg  [1:0]  stoSync1;
  reg  [1:0]  stoSync2;
  reg  [3:0]  activePrev;
  reg  [31:0] msCount;
  reg  [15:0] discMs;
  reg         cmdBusy;
  integer     i;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  // a write lands only in the access phase; pready never stalls it
  wire        wrEn = psel & penable & pwrite;

  // word 0 fields; reserved bits must be zero or the command is refused
  wire [3:0]  cmdField = cmdWord[`SCB_CMD_HI:`SCB_CMD_LO];   // R1
  wire [3:0]  blkField = cmdWord[`SCB_BLK_HI:`SCB_BLK_LO];
  wire        cmdWellFormed = cmdWord[`SCB_MODE_BIT] & (cmdWord[14:12] == 3'h0)
                              & (cmdWord[7:4] == 4'h0);       // R1

  // the go strobe is a write of one to the control word
  wire        cmdGo = wrEn & (paddr == `SCB_OFF_CTRL) & pwdata[0];

  // ten aligned words; the same offsets write the buffer and read the reply
  wire        inBlk = (paddr >= `SCB_OFF_RESP0) && (paddr <= `SCB_OFF_RESP_LAST)
                      && (paddr[1:0] == 2'b00);
  wire [3:0]  blkIdx = paddr[5:2] - 4'h0;

  // polarity one makes a pin that carries current active, zero the reverse
  wire [3:0]  active = ~(pinSync2 ^ inPolarity);               // R13

  // apb answers at once; unmapped addresses flag an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~((paddr == `SCB_OFF_CMD) | (paddr == `SCB_OFF_CTRL)
                   | (paddr == `SCB_OFF_STATUS) | inBlk);

  // read data is zero outside a read, so a late sample never shows a stale word
  assign prdata  = ~(psel & penable & ~pwrite) ? 32'h0 :
                   (paddr == `SCB_OFF_CMD) ? {16'h0, cmdWord} :
                   (paddr == `SCB_OFF_STATUS) ? {29'h0, cmdBusy, discrepancyFault,
                                                 configError} :
                   inBlk ? {16'h0, respWord[paddr[5:2] - 4'h0]} : 32'h0;

  // function uniqueness: any non general code shared by two inputs is an error
  function dupFunc;
    input [15:0] w2;
    input [15:0] w3;
    input [15:0] w4;
    input [15:0] w5;
    reg   [3:0]  a;
    reg   [3:0]  b;
    reg   [3:0]  c;
    reg   [3:0]  d;
    begin
      a = w2[3:0];
      b = w3[3:0];
      c = w4[3:0];
      d = w5[3:0];
      dupFunc = (a != 4'h0 && (a == b || a == c || a == d))
                || (b != 4'h0 && (b == c || b == d))
                || (c != 4'h0 && c == d);                       // R14
    end
  endfunction

  // a code above home is refused as a whole block
  function badCode;
    input [15:0] w2;
    input [15:0] w3;
    input [15:0] w4;
    input [15:0] w5;
    begin
      badCode = (w2[3:0] > `SCB_FN_HOME) || (w3[3:0] > `SCB_FN_HOME)
                || (w4[3:0] > `SCB_FN_HOME) || (w5[3:0] > `SCB_FN_HOME);   // R22
    end
  endfunction

  // a zero limit switches the check off and is always accepted
  wire [15:0] limitNew = blkWord[6];
  wire        limitBad = (limitNew != 16'h0) &&
                         ((limitNew < `SCB_DISC_MIN_MS) || (limitNew > `SCB_DISC_MAX_MS));

  // ****************************************************************
  // command execution and host side writes
  // ****************************************************************
  // commands complete in the cycle they are started, so busy is only a
  // single cycle marker the host can ignore
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      cmdWord     <= 16'h0;
      cmdBusy     <= 1'b0;
      configError <= 1'b0;
      bigEndian   <= `SCB_RST_ENDIAN;
      inPolarity  <= `SCB_RST_POLARITY;
      discLimitMs <= `SCB_RST_LIMIT;
      // reply and buffer clear together so a read after reset shows zeros
      for (i = 0; i < 10; i = i + 1)
      begin
        blkWord[i]  <= 16'h0;
        respWord[i] <= 16'h0;
      end
      for (i = 0; i < 4; i = i + 1)
        inFunc[i] <= `SCB_FN_GP;
    end
    else
    begin
      cmdBusy <= cmdGo;
      if (wrEn && paddr == `SCB_OFF_CMD)
        cmdWord <= pwdata[15:0];
      if (wrEn && paddr == `SCB_OFF_STATUS && pwdata[0])
        configError <= 1'b0;
      if (wrEn && inBlk)
        blkWord[blkIdx] <= pwdata[15:0];
      if (cmdGo)
      begin
        for (i = 0; i < 10; i = i + 1)
          respWord[i] <= 16'h0;
        if (!cmdWellFormed)
          configError <= 1'b1;
        else if (cmdField == `SCB_CMD_STATUS)
        begin
          // snapshot taken at the go strobe; words 3 to 5 stay zero
          respWord[0] <= `SCB_HDR_STATUS;                       // R2
          respWord[1] <= 16'h0;                                 // R2
          respWord[2] <= {FW_MAJOR[7:0], FW_MINOR[7:0]};        // R3
          respWord[6] <= statusWord0;                           // R4
          respWord[7] <= statusWord1;                           // R4
          respWord[8] <= busVoltage;                            // R5
          respWord[9] <= cpuTemp;                               // R6
        end
        else if (cmdField == `SCB_CMD_READ)
        begin
          // only word 0 matters here; the block buffer is not looked at R7
          case (blkField)                                       // R8
            `SCB_BLK_DATA:
            begin
              respWord[0] <= `SCB_HDR_DATA;                     // R9
              respWord[2] <= {15'h0, bigEndian};
            end
            `SCB_BLK_IO:
            begin
              respWord[0] <= `SCB_HDR_IO;                       // R9
              for (i = 0; i < 4; i = i + 1)
                respWord[2 + i] <= {7'h0, inPolarity[i], 4'h0, inFunc[i]};
              respWord[6] <= discLimitMs;
            end
            `SCB_BLK_MOTOR, `SCB_BLK_VEL, `SCB_BLK_POS:
              // loop blocks live elsewhere; only the header comes back here
              respWord[0] <= {4'h8, `SCB_CMD_WRITE, 4'h0, blkField};
            `SCB_BLK_DEFAULTS:
            begin
              bigEndian   <= `SCB_RST_ENDIAN;                   // R10
              inPolarity  <= `SCB_RST_POLARITY;
              discLimitMs <= `SCB_RST_LIMIT;
              for (i = 0; i < 4; i = i + 1)
                inFunc[i] <= `SCB_FN_GP;
            end
            default:
              configError <= 1'b1;
          endcase
        end
        // data block: only the word order bit is kept
        else if (cmdField == `SCB_CMD_WRITE && blkField == `SCB_BLK_DATA)
          bigEndian <= blkWord[2][0];                           // R11
        // the io block is judged whole, so a bad word never leaves half a setup
        else if (cmdField == `SCB_CMD_WRITE && blkField == `SCB_BLK_IO)
        begin
          if (blkWord[0] != `SCB_HDR_IO || limitBad
              || dupFunc(blkWord[2], blkWord[3], blkWord[4], blkWord[5])
              || badCode(blkWord[2], blkWord[3], blkWord[4], blkWord[5]))
            configError <= 1'b1;                                // R14
          else
          begin
            for (i = 0; i < 4; i = i + 1)
            begin
              inPolarity[i] <= blkWord[2 + i][`SCB_POL_BIT];    // R12
              inFunc[i]     <= blkWord[2 + i][`SCB_FN_HI:`SCB_FN_LO];
            end
            discLimitMs <= limitNew;                            // R23
          end
        end
      end
    end
  end

  // ****************************************************************
  // input conditioning and motion functions
  // ****************************************************************
  // pins are asynchronous, so two flops before anything looks at them
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      pinSync1   <= 4'h0;
      pinSync2   <= 4'h0;
      stoSync1   <= 2'h0;
      stoSync2   <= 2'h0;
      activePrev <= 4'h0;
    end
    else
    begin
      pinSync1   <= inputPins;
      pinSync2   <= pinSync1;
      // cutoff channels get the same two flop treatment as the pins
      stoSync1   <= {fourthInputCutoff, thirdInputCutoff};
      stoSync2   <= stoSync1;
      activePrev <= active;
    end
  end

  // limits and home are levels, the rest fire on inactive-to-active edges
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      inputState    <= 4'h0;
      cwLimit       <= 1'b0;
      ccwLimit      <= 1'b0;
      captureStrobe <= 1'b0;
      indexStart    <= 1'b0;
      stopStrobe    <= 1'b0;
      emergencyStop <= 1'b0;
      homeSensor    <= 1'b0;
    end
    else
    begin
      inputState    <= active;                                  // R17
      cwLimit       <= 1'b0;
      ccwLimit      <= 1'b0;
      captureStrobe <= 1'b0;
      indexStart    <= 1'b0;
      stopStrobe    <= 1'b0;
      emergencyStop <= 1'b0;
      homeSensor    <= 1'b0;
      // each function sits on one input at most, so or-ing them in is safe
      for (i = 0; i < 4; i = i + 1)
      begin
        case (inFunc[i])
          `SCB_FN_CW:
            if (active[i]) cwLimit <= 1'b1;                     // R18
          `SCB_FN_CCW:
            if (active[i]) ccwLimit <= 1'b1;                    // R18
          `SCB_FN_CAPTURE:
            if (active[i] & ~activePrev[i])
            begin
              captureStrobe <= 1'b1;                            // R19
              indexStart    <= 1'b1;                            // R19
            end
          `SCB_FN_STOP:
            if (active[i] & ~activePrev[i])
            begin
              stopStrobe    <= 1'b1;                            // R20
              captureStrobe <= 1'b1;                            // R20
            end
          `SCB_FN_ESTOP:
            if (active[i] & ~activePrev[i]) emergencyStop <= 1'b1;   // R21
          `SCB_FN_HOME:
            if (active[i]) homeSensor <= 1'b1;                  // R22
          default:
            ;
        endcase
      end
    end
  end

  // ****************************************************************
  // torque cutoff discrepancy timer
  // ****************************************************************
  // the two cutoff channels must agree within the limit; a fault holds
  // until reset since it guards a safety function
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      msCount          <= 32'h0;
      discMs           <= 16'h0;
      discrepancyFault <= 1'b0;
    end
    // agreement restarts the count, so short glitches never add up
    else if (!torqueCutoffOption || discLimitMs == 16'h0
             || stoSync2[0] == stoSync2[1])
    begin
      msCount <= 32'h0;                                         // R23
      discMs  <= 16'h0;
    end
    else if (msCount == MS_CYCLES - 1)
    begin
      msCount <= 32'h0;
      discMs  <= discMs + 16'h1;
      if (discMs + 16'h1 >= discLimitMs)
        discrepancyFault <= 1'b1;                               // R23
    end
    else
      msCount <= msCount + 32'h1;
  end

endmodule

// >>> include/scb_regs.vh
`ifndef SCB_REGS_VH
`define SCB_REGS_VH
// apb register byte offsets
`define SCB_OFF_CMD       12'h000
`define SCB_OFF_CTRL      12'h004
`define SCB_OFF_STATUS    12'h008
`define SCB_OFF_RESP0     12'h040
`define SCB_OFF_RESP_LAST 12'h064
// block words and fields
`define SCB_WORD_W        16
`define SCB_MODE_BIT      15
`define SCB_CMD_HI        11
`define SCB_CMD_LO        8
`define SCB_BLK_HI        3
`define SCB_BLK_LO        0
`define SCB_CMD_STATUS    4'h1
`define SCB_CMD_READ      4'h2
`define SCB_CMD_WRITE     4'ha
`define SCB_HDR_STATUS    16'h8100
`define SCB_HDR_DATA      16'h8a01
`define SCB_HDR_IO        16'h8a02
`define SCB_BLK_DATA      4'h1
`define SCB_BLK_IO        4'h2
`define SCB_BLK_MOTOR     4'h3
`define SCB_BLK_VEL       4'h5
`define SCB_BLK_POS       4'h6
`define SCB_BLK_DEFAULTS  4'hf
`define SCB_POL_BIT       8
`define SCB_FN_HI         3
`define SCB_FN_LO         0
// input function codes
`define SCB_FN_GP         4'h0
`define SCB_FN_CW         4'h1
`define SCB_FN_CCW        4'h2
`define SCB_FN_CAPTURE    4'h3
`define SCB_FN_STOP       4'h4
`define SCB_FN_ESTOP      4'h5
`define SCB_FN_HOME       4'h6
// discrepancy timer
`define SCB_DISC_MIN_MS   16'd50
`define SCB_DISC_MAX_MS   16'd3000
`define SCB_CLK_HZ        20000000
`define SCB_MS_CYCLES     (`SCB_CLK_HZ / 1000)
`define SCB_RST_ENDIAN    1'b0
`define SCB_RST_POLARITY  4'hf
`define SCB_RST_LIMIT     16'h0
`endif

// >>> verif/scb_checker.sv
`timescale 1ns/100ps
module scb_checker
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        captureStrobe,
  input wire logic        emergencyStop,
  input wire logic        bigEndian,
  input wire logic        cwLimit,
  input wire logic        discrepancyFault,
  input wire logic        configError
);
  // ************************************
  // bus and event properties
  // ************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  ready_high_a: assert property (pready) else $error("pready low");
  err_phase_a: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
  rdata_idle_a: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside read access");
  rdata_upper_a: assert property (prdata[31:16] == 16'h0) else $error("upper half set");
  unmapped_err_a: assert property (psel && penable && paddr == 12'h080 |-> pslverr)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (psel && penable && paddr == 12'h040 |-> !pslverr)
    else $error("mapped access refused");
  capture_pulse_a: assert property (captureStrobe |=> !captureStrobe) else $error("capture long");
  estop_pulse_a: assert property (emergencyStop |=> !emergencyStop) else $error("estop long");
  fault_hold_a: assert property (discrepancyFault |=> discrepancyFault) else $error("fault lost");
  // reset must clear even though the default disable is held then
  reset_clear_a: assert property (disable iff (1'b0)
    rst |=> !bigEndian && !configError && !discrepancyFault && !cwLimit)
    else $error("outputs not cleared");
  cover property (captureStrobe);
  cover property (emergencyStop);
  cover property (configError);
  cover property (discrepancyFault);
endmodule
bind scb_servo_config_block_handler scb_checker i_chk (.sys_clk(sys_clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .captureStrobe(captureStrobe),
  .emergencyStop(emergencyStop), .bigEndian(bigEndian), .cwLimit(cwLimit),
  .discrepancyFault(discrepancyFault), .configError(configError));

// >>> verif/scb_host_model.sv
`timescale 1ns/100ps
module scb_host_model
(
  input  wire logic        sys_clk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata
);
  // ************************************
  // apb master transfers
  // ************************************
  logic [31:0] dummy;
  // bus idles low until the first transfer
  initial
  begin
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h0;
    pwdata <= 32'h0;
  end
  // request held until pready is seen; released data shows the inverse
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    begin
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (!pready) @(posedge sys_clk);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, dummy);
  endtask
  task rd(input logic [11:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask
  // two idle edges let the reply settle before it is read
  task issue(input logic [15:0] w);
    begin
      wr(12'h000, {16'h0, w});
      wr(12'h004, 32'h1);
      repeat (2) @(posedge sys_clk);
    end
  endtask
  task request(input logic [15:0] w);
    begin
      for (int i = 1; i < 10; i++) wr(12'h040 + 12'(4 * i), 32'h0);
      issue(w);
    end
  endtask
endmodule

// >>> verif/scb_servo_config_block_handler_tb.sv
`timescale 1ns/100ps
module scb_servo_config_block_handler_tb;
  logic        sys_clk = 1'b0;
  logic        rst;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdVal;
  logic [3:0]  inputPins;
  logic        torqueCutoffOption, thirdInputCutoff, fourthInputCutoff;
  logic [15:0] statusWord0, statusWord1, busVoltage, cpuTemp;
  logic [3:0]  inputState;
  logic        cwLimit, ccwLimit, captureStrobe, indexStart, stopStrobe, emergencyStop;
  logic        homeSensor, bigEndian, discrepancyFault, configError;
  int          badCount = 0, totalChecks = 0, hits;
  always #25 sys_clk = ~sys_clk;
  // revision values are arbitrary; short ms count keeps the timer test brief
  scb_servo_config_block_handler #(.FW_MAJOR(8'h01), .FW_MINOR(8'h02), .MS_CYCLES(20)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .statusWord0(statusWord0), .statusWord1(statusWord1), .busVoltage(busVoltage),
    .cpuTemp(cpuTemp),
    .inputPins(inputPins), .torqueCutoffOption(torqueCutoffOption),
    .thirdInputCutoff(thirdInputCutoff), .fourthInputCutoff(fourthInputCutoff),
    .inputState(inputState), .cwLimit(cwLimit), .ccwLimit(ccwLimit),
    .captureStrobe(captureStrobe), .indexStart(indexStart), .stopStrobe(stopStrobe),
    .emergencyStop(emergencyStop), .homeSensor(homeSensor), .bigEndian(bigEndian),
    .discrepancyFault(discrepancyFault), .configError(configError));
  scb_host_model i_host (.sys_clk(sys_clk), .pready(pready), .prdata(prdata), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  // ************************************
  // shared helpers
  // ************************************
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    begin
      totalChecks++;
      if (got !== exp)
      begin
        badCount++;
        $display("wrong value %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task expectWord(input int n, input logic [15:0] exp);
    begin
      i_host.rd(12'h040 + 12'(4 * n), rdVal);
      check($sformatf("reply word %0d", n), {16'h0, exp}, rdVal);
    end
  endtask
  task writeIo(input logic [15:0] a, b, c, d, lim);
    begin
      i_host.wr(12'h040, 32'h8a02);
      i_host.wr(12'h044, 32'h0);
      i_host.wr(12'h048, {16'h0, a});
      i_host.wr(12'h04c, {16'h0, b});
      i_host.wr(12'h050, {16'h0, c});
      i_host.wr(12'h054, {16'h0, d});
      i_host.wr(12'h058, {16'h0, lim});
      i_host.issue(16'h8a02);
    end
  endtask
  // counts a pulse output over a window after an input change
  task countPulses(input logic [3:0] pins, input int which);
    begin
      @(posedge sys_clk);
      inputPins <= pins;
      hits = 0;
      repeat (10)
      begin
        @(posedge sys_clk);
        hits += (which == 0) ? captureStrobe : emergencyStop;
      end
    end
  endtask
  // ************************************
  // scenarios
  // ************************************
  task statusTest;
    logic [15:0] sw0 [2] = '{16'h1234, 16'hedcb};
    logic [15:0] sw1 [2] = '{16'h8001, 16'h7ffe};
    logic [15:0] volt [2] = '{16'd485, 16'd0};
    logic [15:0] temp [2] = '{16'd41, 16'hfff6};
    begin
      foreach (sw0[k])
      begin
        statusWord0 <= sw0[k];
        statusWord1 <= sw1[k];
        busVoltage <= volt[k];
        cpuTemp <= temp[k];
        i_host.request(16'h8100);
        expectWord(0, 16'h8100);
        expectWord(1, 16'h0000);
        expectWord(2, 16'h0102);
        expectWord(6, sw0[k]);
        expectWord(7, sw1[k]);
        expectWord(8, volt[k]);
        expectWord(9, temp[k]);
      end
      $display("status test done");
    end
  endtask
  task dataTest;
    logic [3:0] blk [3] = '{4'h3, 4'h5, 4'h6};
    begin
      i_host.wr(12'h040, 32'h8a01);
      i_host.wr(12'h048, 32'h1);
      i_host.issue(16'h8a01);
      check("bigEndian", 32'h1, {31'h0, bigEndian});
      i_host.request(16'h8201);
      expectWord(0, 16'h8a01);
      expectWord(2, 16'h0001);
      foreach (blk[i])
      begin
        i_host.request({12'h820, blk[i]});
        expectWord(0, {12'h8a0, blk[i]});
      end
      $display("data test done");
    end
  endtask
  task ioTest;
    begin
      writeIo(16'h0103, 16'h0005, 16'h0100, 16'h0100, 16'd3000);
      i_host.request(16'h8202);
      expectWord(0, 16'h8a02);
      expectWord(2, 16'h0103);
      expectWord(3, 16'h0005);
      expectWord(6, 16'd3000);
      countPulses(4'h7, 0);
      check("capture pulses", 32'h1, hits);
      check("input state", 32'h5, {28'h0, inputState});
      countPulses(4'h5, 1);
      check("estop pulses", 32'h1, hits);
      check("input state", 32'h7, {28'h0, inputState});
      $display("io test done");
    end
  endtask
  task errorTest;
    logic [15:0] tab [4][5] = '{'{3, 3, 0, 0, 50}, '{7, 0, 0, 0, 50}, '{0, 0, 0, 0, 49},
                                '{0, 0, 0, 0, 3001}};
    logic [15:0] badCmd [2] = '{16'h0201, 16'h8204};
    begin
      foreach (tab[i])
      begin
        writeIo(tab[i][0], tab[i][1], tab[i][2], tab[i][3], tab[i][4]);
        i_host.rd(12'h008, rdVal);
        check("config error", 32'h1, {31'h0, rdVal[0]});
        i_host.wr(12'h008, 32'h1);
        i_host.rd(12'h008, rdVal);
        check("error cleared", 32'h0, {31'h0, rdVal[0]});
        check("error output", 32'h0, {31'h0, configError});
      end
      // a clear mode bit and an unknown readback block are both refused
      foreach (badCmd[k])
      begin
        i_host.issue(badCmd[k]);
        check("command refused", 32'h1, {31'h0, configError});
        i_host.wr(12'h008, 32'h1);
      end
      i_host.rd(12'h080, rdVal);
      check("unmapped read", 32'h0, rdVal);
      $display("error test done");
    end
  endtask
  task defaultsTest;
    begin
      i_host.request(16'h820f);
      check("bigEndian", 32'h0, {31'h0, bigEndian});
      expectWord(0, 16'h0000);
      i_host.request(16'h8202);
      expectWord(2, 16'h0100);
      $display("defaults test done");
    end
  endtask
  task faultTest;
    begin
      writeIo(16'h0000, 16'h0000, 16'h0100, 16'h0100, 16'd50);
      torqueCutoffOption <= 1'b1;
      thirdInputCutoff <= 1'b1;
      repeat (900) @(posedge sys_clk);
      check("early fault", 32'h0, {31'h0, discrepancyFault});
      // channels agree briefly, which must restart the count
      fourthInputCutoff <= 1'b1;
      repeat (10) @(posedge sys_clk);
      thirdInputCutoff <= 1'b0;
      repeat (900) @(posedge sys_clk);
      check("fault after agree", 32'h0, {31'h0, discrepancyFault});
      repeat (200) @(posedge sys_clk);
      check("fault", 32'h1, {31'h0, discrepancyFault});
      // only a reset clears the fault; this also exercises a mid run reset
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      check("fault after reset", 32'h0, {31'h0, discrepancyFault});
      check("order after reset", 32'h0, {31'h0, bigEndian});
      i_host.request(16'h8202);
      expectWord(2, 16'h0100);
      expectWord(6, 16'h0000);
      $display("fault test done");
    end
  endtask
  task completeRun;
    begin
      $display("checks %0d mismatches %0d", totalChecks, badCount);
      if (badCount == 0 && totalChecks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // run is near 2700 cycles; the watchdog allows about seven times that
  initial
  begin
    #1000000;
    badCount++;
    completeRun;
  end
  initial
  begin
    rst <= 1'b1;
    inputPins <= 4'h2;
    torqueCutoffOption <= 1'b0;
    thirdInputCutoff <= 1'b0;
    fourthInputCutoff <= 1'b0;
    statusWord0 <= 16'h0;
    statusWord1 <= 16'h0;
    busVoltage <= 16'h0;
    cpuTemp <= 16'h0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    statusTest;
    dataTest;
    ioTest;
    errorTest;
    defaultsTest;
    faultTest;
    completeRun;
  end
endmodule
